// ===== src/ldm_line_diag_maint_control.sv
// Summary of operation
// - slicer threshold field gives mark level 40/50/60/70 percent, default 50.
// - monitor gain field gives receive boost of 0, 22, 26 or 32 dB.
// - pattern 00 passes data, or zeros with pattern clock 1; 01 sends ones.
// - pattern 10 sends 2^15-1 sequence in E1, 2^20-1 sequence in T1/J1.
// - pattern 11 repeats programmable inband code, default 00001.
// - pattern clock select picks transmit clock (0) or master clock (1).
// - invert bit inverts random data on transmit and in the detector.
// - criterion bit selects which loss/alarm detection standard applies.
// - alarm enable substitutes alarm signal on receive rails during loss.
// - auto all-ones sends ones during loss, only with pattern 00 and pattern clock 0.
// - bit 3 enables automatic remote loopback.
// - bit 2 loops received line data back toward the line.
// - bit 1 enables analog loopback.
// - bit 0 enables digital loopback.
// - transmit code length selects 5 to 8 low code bits, default 5.
// - receive activate code length selects 5 to 8 bits, default 5.
// - receive deactivate code length selects 5 to 8 bits, default 6.
// - transmit code register holds 8-bit code, default 00001.
module ldm_line_diag_maint_control
    import ldm_pkg::*;
(
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // control port
    input wire logic [7:0] ADDR_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [7:0] WDATA_I,
    output logic [7:0] RDATA_O,
    // mode and line status
    input wire logic E1_MODE_I,
    input wire logic LOSS_I,
    input wire logic ACT_CODE_SEEN_I,
    // transmit path
    input wire logic TRANSMIT_CLOCK_TICK_I,
    input wire logic MCLK_TICK_I,
    input wire logic TX_DATA_I,
    output logic TX_LINE_O,
    // receive path
    input wire logic RX_TICK_I,
    input wire logic RX_POS_I,
    input wire logic RX_NEG_I,
    output logic RX_POS_O,
    output logic RX_NEG_O,
    output logic RX_CLK_SUBST_O,
    output logic PRBS_ERR_O,
    // analog and loopback controls
    output ldm_cfg_t CFG_O,
    output logic [6:0] SLICE_PCT_O,
    output logic [5:0] MON_GAIN_DB_O,
    output logic REMOTE_LOOP_O
);

    // ****************************************
    // register file
    // ****************************************
    ldm_cfg_t cfg_q, cfg_d;
    logic [7:0] rdata_q, rdata_d;
    wire sel_receiver_config_two = ADDR_I == ADDR_RECEIVER_CONFIG_TWO;
    wire sel_m0 = ADDR_I == ADDR_MAINT_CONTROL_ZERO;
    wire sel_m1 = ADDR_I == ADDR_MAINT_CONTROL_ONE;
    wire sel_m2 = ADDR_I == ADDR_MAINT_CONTROL_TWO;
    wire sel_code = ADDR_I == ADDR_TX_INBAND_CODE;

    wire [7:0] rd_receiver_config_two = {2'h0, cfg_q.slicer_threshold, RSV_RCF_VALUE,
                          cfg_q.monitor_gain};
    wire [7:0] rd_m0 = {1'b0, cfg_q.pattern_select,
                        cfg_q.pattern_clock_select, cfg_q.sequence_invert,
                        cfg_q.loss_alarm_criterion,
                        cfg_q.alarm_during_loss_enable, cfg_q.auto_all_ones};
    wire [7:0] rd_m1 = {4'h0, cfg_q.auto_remote_loop_enable,
                        cfg_q.remote_loop_enable, cfg_q.analog_loop_enable,
                        cfg_q.digital_loop_enable};
    wire [7:0] rd_m2 = {2'h0, cfg_q.tx_inband_code_length,
                        cfg_q.rx_activate_code_length,
                        cfg_q.rx_deactivate_code_length};

    always_comb begin
        cfg_d = cfg_q;
        if (WR_I && sel_receiver_config_two) begin
            cfg_d.slicer_threshold = WDATA_I[SLICE_LSB +: 2];
            cfg_d.monitor_gain = WDATA_I[GAIN_LSB +: 2];
        end
        if (WR_I && sel_m0) begin
            cfg_d.pattern_select = ldm_pat_t'(WDATA_I[PATT_LSB +: 2]);
            cfg_d.pattern_clock_select = WDATA_I[PCLK_BIT];
            cfg_d.sequence_invert = WDATA_I[INV_BIT];
            cfg_d.loss_alarm_criterion = WDATA_I[CRIT_BIT];
            cfg_d.alarm_during_loss_enable = WDATA_I[ALARM_DURING_LOSS_ENABLE_BIT];
            cfg_d.auto_all_ones = WDATA_I[AUTO_ALL_ONES_BIT];
        end
        if (WR_I && sel_m1) begin
            cfg_d.auto_remote_loop_enable = WDATA_I[AUTO_REMOTE_LOOP_ENABLE_BIT];
            cfg_d.remote_loop_enable = WDATA_I[RLP_BIT];
            cfg_d.analog_loop_enable = WDATA_I[ALP_BIT];
            cfg_d.digital_loop_enable = WDATA_I[DLP_BIT];
        end
        if (WR_I && sel_m2) begin
            cfg_d.tx_inband_code_length = WDATA_I[TXLEN_LSB +: 2];
            cfg_d.rx_activate_code_length =
                WDATA_I[RXALEN_LSB +: 2];
            cfg_d.rx_deactivate_code_length =
                WDATA_I[RXDLEN_LSB +: 2];
        end
        if (WR_I && sel_code) begin
            cfg_d.tx_inband_code = WDATA_I;
        end
    end

    assign rdata_d = !RD_I ? rdata_q :
                     sel_receiver_config_two ? rd_receiver_config_two :
                     sel_m0 ? rd_m0 :
                     sel_m1 ? rd_m1 :
                     sel_m2 ? rd_m2 :
                     sel_code ? cfg_q.tx_inband_code : READ_ZERO;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            cfg_q <= CFG_RESET;
            rdata_q <= READ_ZERO;
        end else begin
            cfg_q <= cfg_d;
            rdata_q <= rdata_d;
        end
    end

    assign RDATA_O = rdata_q;
    assign CFG_O = cfg_q;

    // ****************************************
    // analog setting decode
    // ****************************************
    logic [6:0] slice_pct_q;
    logic [5:0] gain_db_q;
    wire [6:0] slice_pct_d = cfg_q.slicer_threshold == 2'h0 ? SLICE_PCT_40 :
                             cfg_q.slicer_threshold == 2'h1 ? SLICE_PCT_50 :
                             cfg_q.slicer_threshold == 2'h2 ? SLICE_PCT_60 :
                             SLICE_PCT_70;
    wire [5:0] gain_db_d = cfg_q.monitor_gain == 2'h0 ? GAIN_DB_0 :
                           cfg_q.monitor_gain == 2'h1 ? GAIN_DB_22 :
                           cfg_q.monitor_gain == 2'h2 ? GAIN_DB_26 :
                           GAIN_DB_32;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            slice_pct_q <= SLICE_PCT_50;
            gain_db_q <= GAIN_DB_0;
        end else begin
            slice_pct_q <= slice_pct_d;
            gain_db_q <= gain_db_d;
        end
    end

    assign SLICE_PCT_O = slice_pct_q;
    assign MON_GAIN_DB_O = gain_db_q;

    // ****************************************
    // transmit pattern generator
    // ****************************************
    logic [14:0] gen15_q;
    logic [19:0] gen20_q;
    logic [2:0] code_idx_q;
    logic tx_line_q;
    wire tx_tick = cfg_q.pattern_clock_select ? MCLK_TICK_I
                                              : TRANSMIT_CLOCK_TICK_I;
    wire fb15 = gen15_q[P15_TAP_A] ^ gen15_q[P15_TAP_B];
    wire fb20 = gen20_q[Q20_TAP_A] ^ gen20_q[Q20_TAP_B];
    wire rand_bit = (E1_MODE_I ? fb15 : fb20)
                    ^ cfg_q.sequence_invert;
    wire [3:0] code_len = CODE_LEN_MIN
                          + {2'h0, cfg_q.tx_inband_code_length};
    wire [3:0] code_last = code_len - 4'h1;
    wire code_over = {1'b0, code_idx_q} > code_last;
    wire [3:0] code_pos = code_over ? 4'h0
                          : code_last - {1'b0, code_idx_q};
    wire code_bit = cfg_q.tx_inband_code[code_pos[2:0]];
    wire code_wrap = {1'b0, code_idx_q} >= code_last;
    wire [2:0] code_idx_d = code_wrap ? 3'h0 : code_idx_q + 3'h1;
    wire auto_ones = cfg_q.auto_all_ones && LOSS_I;
    wire remote_loop = cfg_q.remote_loop_enable
        || (cfg_q.auto_remote_loop_enable && ACT_CODE_SEEN_I);
    wire normal_bit = cfg_q.pattern_clock_select ? 1'b0
                    : (auto_ones || TX_DATA_I);
    wire pat_bit = cfg_q.pattern_select == PAT_ONES ? 1'b1 :
                   cfg_q.pattern_select == PAT_RANDOM ? rand_bit :
                   cfg_q.pattern_select == PAT_CODE ? code_bit :
                   normal_bit;
    wire rx_mark = RX_POS_I || RX_NEG_I;
    wire tx_bit = remote_loop ? rx_mark : pat_bit;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            gen15_q <= P15_SEED;
            gen20_q <= Q20_SEED;
            code_idx_q <= 3'h0;
            tx_line_q <= 1'b0;
        end else if (tx_tick) begin
            gen15_q <= {gen15_q[13:0], fb15};
            gen20_q <= {gen20_q[18:0], fb20};
            code_idx_q <= code_idx_d;
            tx_line_q <= tx_bit;
        end
    end

    assign TX_LINE_O = tx_line_q;
    assign REMOTE_LOOP_O = remote_loop;

    // ****************************************
    // receive sequence checker
    // ****************************************
    logic [14:0] chk15_q;
    logic [19:0] chk20_q;
    logic prbs_err_q;
    wire rx_seq = rx_mark ^ cfg_q.sequence_invert;
    wire pred = E1_MODE_I ? chk15_q[P15_TAP_A] ^ chk15_q[P15_TAP_B]
                          : chk20_q[Q20_TAP_A] ^ chk20_q[Q20_TAP_B];

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            chk15_q <= P15_SEED;
            chk20_q <= Q20_SEED;
            prbs_err_q <= 1'b0;
        end else begin
            prbs_err_q <= RX_TICK_I && (rx_seq != pred);
            if (RX_TICK_I) begin
                chk15_q <= {chk15_q[13:0], rx_seq};
                chk20_q <= {chk20_q[18:0], rx_seq};
            end
        end
    end

    assign PRBS_ERR_O = prbs_err_q;

    // ****************************************
    // alarm substitution on receive rails
    // ****************************************
    logic rx_pos_q, rx_neg_q, ais_phase_q, clk_subst_q;
    wire ais_on = cfg_q.alarm_during_loss_enable && LOSS_I;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            rx_pos_q <= 1'b0;
            rx_neg_q <= 1'b0;
            ais_phase_q <= 1'b0;
            clk_subst_q <= 1'b0;
        end else begin
            clk_subst_q <= ais_on;
            if (RX_TICK_I) begin
                ais_phase_q <= !ais_phase_q;
                rx_pos_q <= ais_on ? !ais_phase_q : RX_POS_I;
                rx_neg_q <= ais_on ? ais_phase_q : RX_NEG_I;
            end
        end
    end

    assign RX_POS_O = rx_pos_q;
    assign RX_NEG_O = rx_neg_q;
    assign RX_CLK_SUBST_O = clk_subst_q;

    // ****************************************
    // checks
    // ****************************************
    a_slice_decode: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        SLICE_PCT_O == ($past(cfg_q.slicer_threshold) == 2'h0 ? SLICE_PCT_40
            : $past(cfg_q.slicer_threshold) == 2'h1 ? SLICE_PCT_50
            : $past(cfg_q.slicer_threshold) == 2'h2 ? SLICE_PCT_60
            : SLICE_PCT_70))
        else $error("slicer percent wrong");

    a_gain_decode: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        MON_GAIN_DB_O == ($past(cfg_q.monitor_gain) == 2'h0 ? GAIN_DB_0
            : $past(cfg_q.monitor_gain) == 2'h1 ? GAIN_DB_22
            : $past(cfg_q.monitor_gain) == 2'h2 ? GAIN_DB_26
            : GAIN_DB_32))
        else $error("monitor gain wrong");

    a_ones_sent: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (tx_tick && !remote_loop && cfg_q.pattern_select == PAT_ONES)
            |=> TX_LINE_O)
        else $error("all ones not sent");

    a_zeros_sent: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (tx_tick && !remote_loop && cfg_q.pattern_clock_select
            && cfg_q.pattern_select == PAT_NORMAL) |=> !TX_LINE_O)
        else $error("all zeros not sent");

    a_loss_ones: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (tx_tick && !remote_loop && LOSS_I && cfg_q.auto_all_ones
            && !cfg_q.pattern_clock_select
            && cfg_q.pattern_select == PAT_NORMAL) |=> TX_LINE_O)
        else $error("auto all ones missing");

    a_random_bit: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (tx_tick && !remote_loop && cfg_q.pattern_select == PAT_RANDOM
            && E1_MODE_I && !cfg_q.sequence_invert)
            |=> TX_LINE_O == $past(gen15_q[P15_TAP_A] ^ gen15_q[P15_TAP_B]))
        else $error("random bit wrong");

    a_code_bit: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (tx_tick && !remote_loop && cfg_q.pattern_select == PAT_CODE
            && code_idx_q == 3'h0 && cfg_q.tx_inband_code_length == 2'h0)
            |=> TX_LINE_O == $past(cfg_q.tx_inband_code[4]))
        else $error("code bit wrong");

    a_remote_loop: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (tx_tick && cfg_q.remote_loop_enable)
            |=> TX_LINE_O == $past(RX_POS_I || RX_NEG_I))
        else $error("remote loop data wrong");

    a_ais_rails: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (RX_TICK_I && LOSS_I && cfg_q.alarm_during_loss_enable)
            |=> (RX_POS_O ^ RX_NEG_O) && RX_CLK_SUBST_O)
        else $error("alarm not substituted");

    a_rx_pass: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (RX_TICK_I && !(LOSS_I && cfg_q.alarm_during_loss_enable))
            |=> RX_POS_O == $past(RX_POS_I) && RX_NEG_O == $past(RX_NEG_I)
            && !RX_CLK_SUBST_O)
        else $error("rails not passed through");

    a_reserved_read: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (RD_I && sel_receiver_config_two) |=> RDATA_O[RSV_RCF_LSB +: 2] == RSV_RCF_VALUE)
        else $error("reserved bits wrong");

    a_write_back: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (WR_I && sel_code) |=> CFG_O.tx_inband_code == $past(WDATA_I))
        else $error("code register not written");

    a_code_read: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (RD_I && sel_code) |=> RDATA_O == $past(CFG_O.tx_inband_code))
        else $error("code readback wrong");

endmodule

// ===== src/ldm_pkg.sv
package ldm_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] ADDR_RECEIVER_CONFIG_TWO = 8'h0C;
    localparam logic [7:0] ADDR_MAINT_CONTROL_ZERO = 8'h0D;
    localparam logic [7:0] ADDR_MAINT_CONTROL_ONE = 8'h0E;
    localparam logic [7:0] ADDR_MAINT_CONTROL_TWO = 8'h0F;
    localparam logic [7:0] ADDR_TX_INBAND_CODE = 8'h10;

    // ****************************************
    // field positions
    // ****************************************
    localparam int SLICE_LSB = 4;
    localparam int RSV_RCF_LSB = 2;
    localparam int GAIN_LSB = 0;
    localparam int PATT_LSB = 5;
    localparam int PCLK_BIT = 4;
    localparam int INV_BIT = 3;
    localparam int CRIT_BIT = 2;
    localparam int ALARM_DURING_LOSS_ENABLE_BIT = 1;
    localparam int AUTO_ALL_ONES_BIT = 0;
    localparam int AUTO_REMOTE_LOOP_ENABLE_BIT = 3;
    localparam int RLP_BIT = 2;
    localparam int ALP_BIT = 1;
    localparam int DLP_BIT = 0;
    localparam int TXLEN_LSB = 4;
    localparam int RXALEN_LSB = 2;
    localparam int RXDLEN_LSB = 0;

    // ****************************************
    // reset values and reserved contents
    // ****************************************
    localparam logic [1:0] RST_SLICE = 2'h1;
    localparam logic [1:0] RSV_RCF_VALUE = 2'h2;
    localparam logic [1:0] RST_RXD_LEN = 2'h1;
    localparam logic [7:0] RST_TX_CODE = 8'h01;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ****************************************
    // decoded analog settings
    // ****************************************
    localparam logic [6:0] SLICE_PCT_40 = 7'h28;
    localparam logic [6:0] SLICE_PCT_50 = 7'h32;
    localparam logic [6:0] SLICE_PCT_60 = 7'h3C;
    localparam logic [6:0] SLICE_PCT_70 = 7'h46;
    localparam logic [5:0] GAIN_DB_0 = 6'h00;
    localparam logic [5:0] GAIN_DB_22 = 6'h16;
    localparam logic [5:0] GAIN_DB_26 = 6'h1A;
    localparam logic [5:0] GAIN_DB_32 = 6'h20;

    // ****************************************
    // pattern generator constants
    // ****************************************
    localparam logic [3:0] CODE_LEN_MIN = 4'h5;
    localparam int P15_TAP_A = 14;
    localparam int P15_TAP_B = 13;
    localparam int Q20_TAP_A = 19;
    localparam int Q20_TAP_B = 16;
    localparam logic [14:0] P15_SEED = 15'h7FFF;
    localparam logic [19:0] Q20_SEED = 20'hF_FFFF;

    typedef enum logic [1:0] {
        PAT_NORMAL = 2'h0,
        PAT_ONES = 2'h1,
        PAT_RANDOM = 2'h2,
        PAT_CODE = 2'h3
    } ldm_pat_t;

    typedef struct packed {
        logic [1:0] slicer_threshold;
        logic [1:0] monitor_gain;
        ldm_pat_t pattern_select;
        logic pattern_clock_select;
        logic sequence_invert;
        logic loss_alarm_criterion;
        logic alarm_during_loss_enable;
        logic auto_all_ones;
        logic auto_remote_loop_enable;
        logic remote_loop_enable;
        logic analog_loop_enable;
        logic digital_loop_enable;
        logic [1:0] tx_inband_code_length;
        logic [1:0] rx_activate_code_length;
        logic [1:0] rx_deactivate_code_length;
        logic [7:0] tx_inband_code;
    } ldm_cfg_t;

    localparam ldm_cfg_t CFG_RESET = '{
        slicer_threshold: RST_SLICE,
        pattern_select: PAT_NORMAL,
        rx_deactivate_code_length: RST_RXD_LEN,
        tx_inband_code: RST_TX_CODE,
        default: '0
    };

endpackage

// ===== sim/testbench.sv
module testbench
    import ldm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic clk, rst, wr, rd, e1, loss, act_seen;
    logic transmit_clock_t, mclk_t, tx_d, rx_t, rx_p, rx_n;
    logic [7:0] addr, wdata, rdata;
    logic tx_line, rxp_o, rxn_o, rx_sub, perr, rloop;
    logic [6:0] slice_pct;
    logic [5:0] gain_db;
    ldm_cfg_t cfg;
    int n_fail, check_count;
    logic [7:0] adrs [0:4] = '{8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10};

    ldm_line_diag_maint_control uut (
        .CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WR_I(wr), .RD_I(rd),
        .WDATA_I(wdata), .RDATA_O(rdata), .E1_MODE_I(e1), .LOSS_I(loss),
        .ACT_CODE_SEEN_I(act_seen), .TRANSMIT_CLOCK_TICK_I(transmit_clock_t),
        .MCLK_TICK_I(mclk_t), .TX_DATA_I(tx_d), .TX_LINE_O(tx_line),
        .RX_TICK_I(rx_t), .RX_POS_I(rx_p), .RX_NEG_I(rx_n),
        .RX_POS_O(rxp_o), .RX_NEG_O(rxn_o), .RX_CLK_SUBST_O(rx_sub),
        .PRBS_ERR_O(perr), .CFG_O(cfg), .SLICE_PCT_O(slice_pct),
        .MON_GAIN_DB_O(gain_db), .REMOTE_LOOP_O(rloop)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    task automatic chk_byte(input logic [7:0] got, exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, d);
        step();
        addr = a;
        wdata = d;
        wr = 1'b1;
        step();
        wr = 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        step();
        addr = a;
        rd = 1'b1;
        step();
        rd = 1'b0;
        d = rdata;
    endtask

    task automatic tx_bit(input logic use_m, output logic b);
        step();
        if (use_m) mclk_t = 1'b1;
        else transmit_clock_t = 1'b1;
        step();
        transmit_clock_t = 1'b0;
        mclk_t = 1'b0;
        b = tx_line;
    endtask

    task automatic rx_bit(input logic p, n);
        step();
        rx_p = p;
        rx_n = n;
        rx_t = 1'b1;
        step();
        rx_t = 1'b0;
    endtask

    function automatic logic rec_ok(input logic [63:0] c, input int a, l,
                                    input logic inv);
        logic ok;
        ok = 1'b1;
        for (int n = l; n < 64; n++) begin
            if (c[n] !== (c[n-a] ^ c[n-l] ^ inv)) ok = 1'b0;
        end
        return ok;
    endfunction

    function automatic logic rot_ok(input logic [15:0] c,
                                    input logic [7:0] code, input int len);
        logic hit, any;
        any = 1'b0;
        for (int r = 0; r < len; r++) begin
            hit = 1'b1;
            for (int i = 0; i < 16; i++) begin
                if (c[i] !== code[len - 1 - ((i + r) % len)]) hit = 1'b0;
            end
            if (hit) any = 1'b1;
        end
        return any;
    endfunction

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs();
        logic [7:0] d;
        logic [7:0] dflt [0:4] = '{8'h18, 8'h00, 8'h00, 8'h01, 8'h01};
        logic [7:0] full [0:4] = '{8'h3B, 8'h7F, 8'h0F, 8'h3F, 8'hFF};
        for (int i = 0; i < 5; i++) begin
            rd_reg(adrs[i], d);
            chk_byte(d, dflt[i], "reset value");
            wr_reg(adrs[i], 8'hFF);
            rd_reg(adrs[i], d);
            chk_byte(d, full[i], "reserved bits");
        end
        chk_bit(cfg.loss_alarm_criterion, 1'b1, "criterion");
        chk_bit(cfg.analog_loop_enable, 1'b1, "analog loop");
        chk_bit(cfg.digital_loop_enable, 1'b1, "digital loop");
        for (int i = 0; i < 5; i++) wr_reg(adrs[i], 8'h00);
        rd_reg(8'h0C, d);
        chk_byte(d, 8'h08, "reserved default kept");
        chk_bit(cfg.loss_alarm_criterion, 1'b0, "criterion");
        chk_bit(cfg.analog_loop_enable, 1'b0, "analog loop");
        chk_bit(cfg.digital_loop_enable, 1'b0, "digital loop");
        wr_reg(8'h20, 8'hFF);
        rd_reg(8'h20, d);
        chk_byte(d, 8'h00, "unmapped");
        $display("test regs done");
    endtask

    task automatic t_analog();
        logic [6:0] pct [0:3] = '{7'h28, 7'h32, 7'h3C, 7'h46};
        logic [5:0] db [0:3] = '{6'h00, 6'h16, 6'h1A, 6'h20};
        for (int i = 0; i < 4; i++) begin
            wr_reg(8'h0C, {2'b00, 2'(i), 2'b10, 2'(3 - i)});
            step();
            step();
            chk_byte({1'b0, slice_pct}, {1'b0, pct[i]}, "slicer");
            chk_byte({2'b00, gain_db}, {2'b00, db[3 - i]}, "gain");
        end
        $display("test analog done");
    endtask

    task automatic t_tx_fixed();
        logic b;
        wr_reg(8'h0D, 8'h00);
        tx_d = 1'b1;
        tx_bit(1'b0, b);
        chk_bit(b, 1'b1, "normal data one");
        tx_d = 1'b0;
        tx_bit(1'b0, b);
        chk_bit(b, 1'b0, "normal data zero");
        wr_reg(8'h0D, 8'h20);
        tx_bit(1'b0, b);
        chk_bit(b, 1'b1, "all ones");
        wr_reg(8'h0D, 8'h10);
        tx_d = 1'b1;
        tx_bit(1'b1, b);
        chk_bit(b, 1'b0, "all zeros");
        wr_reg(8'h0D, 8'h30);
        tx_bit(1'b0, b);
        chk_bit(b, 1'b0, "transmit tick ignored");
        tx_bit(1'b1, b);
        chk_bit(b, 1'b1, "master tick used");
        wr_reg(8'h0D, 8'h01);
        tx_d = 1'b0;
        loss = 1'b1;
        tx_bit(1'b0, b);
        chk_bit(b, 1'b1, "ones during loss");
        loss = 1'b0;
        tx_bit(1'b0, b);
        chk_bit(b, 1'b0, "data after loss");
        $display("test tx fixed done");
    endtask

    task automatic t_code(input logic [1:0] len, input logic [7:0] code);
        logic [15:0] c;
        logic b;
        wr_reg(8'h10, code);
        wr_reg(8'h0F, {2'b00, len, 4'h1});
        wr_reg(8'h0D, 8'h60);
        for (int i = 0; i < 16; i++) begin
            tx_bit(1'b0, b);
            c[i] = b;
        end
        b = rot_ok(c, code, int'(len) + 5);
        chk_bit(b, 1'b1, "code");
        $display("test code done");
    endtask

    task automatic t_random(input logic e1m, inv, input int a, ra, l);
        logic [63:0] c;
        logic b;
        int errs;
        e1 = e1m;
        wr_reg(8'h0D, {3'b010, 1'b0, inv, 3'b000});
        tx_bit(1'b0, b);
        tx_bit(1'b0, b);
        for (int i = 0; i < 64; i++) begin
            tx_bit(1'b0, b);
            c[i] = b;
        end
        b = rec_ok(c, a, l, inv) | rec_ok(c, ra, l, inv);
        chk_bit(b, 1'b1, "sequence");
        chk_bit(|c & ~(&c), 1'b1, "sequence varies");
        for (int p = 0; p < 2; p++) begin
            errs = 0;
            for (int i = 0; i < 64; i++) begin
                rx_bit(c[i] ^ (p == 1 && i == 48), 1'b0);
                if (i >= 40 && perr === 1'b1) errs++;
            end
            chk_bit(errs != 0, p[0], "detector");
        end
        $display("test random done");
    endtask

    task automatic t_alarm();
        logic prev;
        wr_reg(8'h0D, 8'h02);
        loss = 1'b1;
        for (int i = 0; i < 4; i++) begin
            rx_bit(1'b0, 1'b0);
            chk_bit(rxp_o ^ rxn_o, 1'b1, "one rail");
            chk_bit(rx_sub, 1'b1, "clock substituted");
            if (i > 0) chk_bit(rxp_o, ~prev, "alternation");
            prev = rxp_o;
        end
        wr_reg(8'h0D, 8'h00);
        rx_bit(1'b1, 1'b0);
        chk_bit(rxp_o, 1'b1, "pos passes");
        chk_bit(rxn_o, 1'b0, "neg passes");
        chk_bit(rx_sub, 1'b0, "no substitution");
        loss = 1'b0;
        $display("test alarm done");
    endtask

    task automatic t_loop();
        logic b;
        wr_reg(8'h0E, 8'h04);
        chk_bit(rloop, 1'b1, "remote loop");
        tx_d = 1'b0;
        rx_p = 1'b1;
        tx_bit(1'b0, b);
        chk_bit(b, 1'b1, "looped mark");
        rx_p = 1'b0;
        tx_d = 1'b1;
        tx_bit(1'b0, b);
        chk_bit(b, 1'b0, "looped space");
        tx_d = 1'b0;
        wr_reg(8'h0E, 8'h08);
        chk_bit(rloop, 1'b0, "auto loop idle");
        act_seen = 1'b1;
        step();
        chk_bit(rloop, 1'b1, "auto loop active");
        wr_reg(8'h0E, 8'h00);
        chk_bit(rloop, 1'b0, "loops off");
        act_seen = 1'b0;
        $display("test loop done");
    endtask

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        {rst, wr, rd, e1, loss, act_seen} = 6'b100000;
        {transmit_clock_t, mclk_t, tx_d, rx_t, rx_p, rx_n} = 6'b000000;
        addr = 8'h00;
        wdata = 8'h00;
        n_fail = 0;
        check_count = 0;
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        chk_byte({1'b0, slice_pct}, 8'h32, "slicer after reset");
        t_regs();
        t_analog();
        t_tx_fixed();
        t_code(2'h0, 8'h01);
        t_code(2'h1, 8'h2D);
        t_code(2'h2, 8'h53);
        t_code(2'h3, 8'hA6);
        t_random(1'b1, 1'b0, 14, 1, 15);
        t_random(1'b1, 1'b1, 14, 1, 15);
        t_random(1'b0, 1'b0, 17, 3, 20);
        t_random(1'b0, 1'b1, 17, 3, 20);
        t_alarm();
        t_loop();
        print_verdict();
    end

    initial begin
        #500_000;
        n_fail++;
        $display("[FAIL] %0t run did not finish", $time);
        print_verdict();
    end

endmodule
